/* File: sfh_pkg.sv */
// Shared constants and types for the host-side SRAM and flash module controller
package sfh_pkg;

    // ==========================================================
    // Array geometry
    localparam int          SFH_ADDR_W       = 19;
    localparam int          SFH_DATA_W       = 32;
    localparam int          SFH_LANES        = 4;
    localparam int          SFH_SECTORS      = 8;
    localparam int          SFH_SECTOR_SHIFT = 16;
    localparam int          SFH_POLL_BIT     = 7;

    // ==========================================================
    // Timing, clock at 20 MHz
    localparam int          SFH_CLK_HZ       = 20000000;
    localparam int          SFH_CLK_NS       = 50;
    localparam int          SFH_SRAM_ACC_NS  = 35;
    localparam int          SFH_FLASH_ACC_NS = 90;
    localparam int          SFH_WR_PULSE_NS  = 45;
    localparam int          SFH_SRAM_ACC_CYC = (SFH_SRAM_ACC_NS + SFH_CLK_NS - 1) / SFH_CLK_NS;
    localparam int          SFH_FLASH_ACC_CYC = (SFH_FLASH_ACC_NS + SFH_CLK_NS - 1) / SFH_CLK_NS;
    localparam int          SFH_WR_PULSE_CYC = (SFH_WR_PULSE_NS + SFH_CLK_NS - 1) / SFH_CLK_NS;
    localparam int          SFH_PROG_TYP_US  = 14;
    localparam int          SFH_SECT_ERASE_S = 30;
    localparam int          SFH_CHIP_ERASE_S = 120;
    localparam logic [31:0] SFH_PROG_TMO_CYC = 32'(64'(SFH_SECT_ERASE_S) * 64'(SFH_CLK_HZ));
    localparam logic [31:0] SFH_SECT_TMO_CYC = 32'(64'(SFH_SECT_ERASE_S) * 64'(SFH_CLK_HZ));
    localparam logic [31:0] SFH_CHIP_TMO_CYC = 32'(64'(SFH_CHIP_ERASE_S) * 64'(SFH_CLK_HZ));

    // ==========================================================
    // Flash command cycle addresses and codes
    localparam logic [18:0] SFH_UNLOCK1_ADDR = 19'h00555;
    localparam logic [18:0] SFH_UNLOCK2_ADDR = 19'h002aa;
    localparam logic [7:0]  SFH_UNLOCK1_DATA = 8'haa;
    localparam logic [7:0]  SFH_UNLOCK2_DATA = 8'h55;
    localparam logic [7:0]  SFH_PROG_CODE    = 8'ha0;
    localparam logic [7:0]  SFH_ERASE_CODE   = 8'h80;
    localparam logic [7:0]  SFH_CHIP_CODE    = 8'h10;
    localparam logic [7:0]  SFH_SECT_CODE    = 8'h30;
    localparam logic [2:0]  SFH_PROG_STEPS   = 3'h4;
    localparam logic [2:0]  SFH_SECT_STEPS   = 3'h5;
    localparam logic [2:0]  SFH_CHIP_STEPS   = 3'h6;

    // ==========================================================
    // Types
    typedef enum logic [2:0] {
        SFH_OP_SRAM_RD,
        SFH_OP_SRAM_WR,
        SFH_OP_FLASH_RD,
        SFH_OP_PROG,
        SFH_OP_SECT_ERASE,
        SFH_OP_CHIP_ERASE
    } sfh_op_e;

    typedef struct packed {
        sfh_op_e     op;
        logic [18:0] addr;
        logic [31:0] data;
        logic [3:0]  lanes;
    } sfh_cmd_s;

    typedef struct packed {
        logic [18:0] addr;
        logic [31:0] data_out;
        logic        data_oe_n;
        logic        sram_select_n;
        logic [3:0]  sram_write_strobe_n;
        logic        flash_select_n;
        logic [3:0]  flash_write_strobe_n;
        logic        output_enable_n;
    } sfh_pins_s;

endpackage

/* File: sfh_cycle.sv */
// Single pin-level bus cycle engine for the shared SRAM and flash bus
`timescale 1ns/100ps
`default_nettype none
module sfh_cycle (
    input  wire logic              ref_clk,  // 20 MHz clock
    input  wire logic              rst,      // Synchronous reset
    input  wire logic              start,    // Begin one bus cycle
    input  wire logic              is_flash, // Target flash, else SRAM
    input  wire logic              is_write, // Write cycle, else read
    input  wire logic [18:0]       addr,     // Word address
    input  wire logic [31:0]       wdata,    // Write data
    input  wire logic [3:0]        lanes,    // Byte lanes to strobe
    input  wire logic [31:0]       data_in,  // Data bus level
    output logic                   done,     // Cycle finished pulse
    output logic [31:0]            rdata,    // Captured read data
    output sfh_pkg::sfh_pins_s     pins      // Module pins
);
    import sfh_pkg::*;

    typedef enum logic [1:0] {SFH_CY_IDLE, SFH_CY_ACT, SFH_CY_REC} sfh_cyc_e;

    sfh_cyc_e   state_reg;
    logic [1:0] cnt_reg;
    logic [1:0] act_last;
    logic       write_reg;
    logic       flash_reg;
    logic [3:0] lanes_reg;
    logic       act_end;

    always_comb begin
        if (write_reg) begin
            act_last = 2'(SFH_WR_PULSE_CYC - 1);
        end else if (flash_reg) begin
            act_last = 2'(SFH_FLASH_ACC_CYC - 1);
        end else begin
            act_last = 2'(SFH_SRAM_ACC_CYC - 1);
        end
    end

    assign act_end = (state_reg == SFH_CY_ACT) && (cnt_reg == act_last);

    // ==========================================================
    // Sequencing
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_reg <= SFH_CY_IDLE;
            cnt_reg   <= 2'h0;
            write_reg <= 1'b0;
            flash_reg <= 1'b0;
            lanes_reg <= 4'h0;
        end else begin
            case (state_reg)
                SFH_CY_IDLE: begin
                    if (start) begin
                        state_reg <= SFH_CY_ACT;
                        cnt_reg   <= 2'h0;
                        write_reg <= is_write;
                        flash_reg <= is_flash;
                        lanes_reg <= lanes;
                    end
                end
                SFH_CY_ACT: begin
                    cnt_reg <= cnt_reg + 2'h1;
                    if (act_end) begin
                        state_reg <= SFH_CY_REC;
                    end
                end
                SFH_CY_REC: state_reg <= SFH_CY_IDLE;
                default:    state_reg <= SFH_CY_IDLE;
            endcase
        end
    end

    // ==========================================================
    // Pin drive: one memory selected at a time, strobe framed by select
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pins <= '{addr: '0, data_out: '0, data_oe_n: 1'b1, sram_select_n: 1'b1,
                      sram_write_strobe_n: 4'hf, flash_select_n: 1'b1,
                      flash_write_strobe_n: 4'hf, output_enable_n: 1'b1};
        end else if (state_reg == SFH_CY_IDLE && start) begin
            pins.addr                 <= addr;
            pins.data_out             <= wdata;
            pins.data_oe_n            <= !is_write;
            pins.sram_select_n        <= is_flash;
            pins.flash_select_n       <= !is_flash;
            pins.output_enable_n      <= is_write;
            pins.sram_write_strobe_n  <= (is_write && !is_flash) ? ~lanes : 4'hf;
            pins.flash_write_strobe_n <= (is_write && is_flash) ? ~lanes : 4'hf;
        end else if (act_end) begin
            pins.data_oe_n            <= 1'b1;
            pins.sram_select_n        <= 1'b1;
            pins.flash_select_n       <= 1'b1;
            pins.output_enable_n      <= 1'b1;
            pins.sram_write_strobe_n  <= 4'hf;
            pins.flash_write_strobe_n <= 4'hf;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            done  <= 1'b0;
            rdata <= 32'h0;
        end else begin
            done <= act_end;
            if (act_end && !write_reg) begin
                rdata <= data_in;
            end
        end
    end

    // ==========================================================
    // Checks
    a_selects_exclusive: assert property (@(posedge ref_clk) disable iff (rst)
        !(!pins.sram_select_n && !pins.flash_select_n))
        else $error("both memories selected");
    a_flash_we_framed: assert property (@(posedge ref_clk) disable iff (rst)
        (pins.flash_write_strobe_n != 4'hf) |-> !pins.flash_select_n && pins.output_enable_n)
        else $error("flash write strobe outside select");
    a_lane_strobes: assert property (@(posedge ref_clk) disable iff (rst)
        (state_reg == SFH_CY_ACT) |->
            ((~pins.flash_write_strobe_n & ~lanes_reg) == 4'h0)
            && ((~pins.sram_write_strobe_n & ~lanes_reg) == 4'h0))
        else $error("write strobe on unrequested lane");
    a_read_no_drive: assert property (@(posedge ref_clk) disable iff (rst)
        !pins.output_enable_n |-> pins.data_oe_n)
        else $error("host drives bus during read");
    a_flash_read_len: assert property (@(posedge ref_clk) disable iff (rst)
        $fell(pins.output_enable_n) && !pins.flash_select_n |->
            !pins.output_enable_n ##1 !pins.output_enable_n ##1 pins.output_enable_n)
        else $error("flash read length wrong");
endmodule
`default_nettype wire

/* File: sfh_ctrl.sv */
// Host controller driving a shared-bus SRAM and sectored flash module
// Operation
// - Program uses four write bus cycles
// - Final program cycle carries location and value
// - Sector erase address selects the sector
// - Flash write framed by strobe or select
`timescale 1ns/100ps
`default_nettype none
module sfh_ctrl #(
    parameter logic [31:0] PROG_TMO_CYC = sfh_pkg::SFH_PROG_TMO_CYC, // Program poll limit
    parameter logic [31:0] SECT_TMO_CYC = sfh_pkg::SFH_SECT_TMO_CYC, // Sector erase limit
    parameter logic [31:0] CHIP_TMO_CYC = sfh_pkg::SFH_CHIP_TMO_CYC  // Chip erase limit
) (
    input  wire logic              ref_clk,      // 20 MHz clock
    input  wire logic              rst,          // Synchronous reset
    input  wire logic              cmd_valid,    // Command offered
    input  wire sfh_pkg::sfh_cmd_s cmd,          // Command
    output logic                   cmd_ready,    // Command accepted when valid
    output logic                   resp_valid,   // Command finished pulse
    output logic [31:0]            resp_data,    // Read or final poll data
    output logic                   resp_timeout, // Poll never matched
    input  wire logic [31:0]       data_in,      // Data bus level
    output sfh_pkg::sfh_pins_s     pins          // Module pins
);
    import sfh_pkg::*;

    typedef enum logic [2:0] {
        SFH_M_IDLE, SFH_M_SEQ, SFH_M_SECT, SFH_M_POLL, SFH_M_DONE
    } sfh_main_e;

    sfh_main_e   state_reg;
    sfh_cmd_s    cmd_reg;
    logic [2:0]  step_reg;
    logic [2:0]  sect_reg;
    logic        wait_reg;
    logic        start_reg;
    logic        eng_flash_reg;
    logic        eng_write_reg;
    logic [18:0] eng_addr_reg;
    logic [31:0] eng_wdata_reg;
    logic [3:0]  eng_lanes_reg;
    logic [18:0] poll_addr_reg;
    logic [31:0] tmo_reg;
    logic        fail_reg;
    logic        eng_done;
    logic [31:0] eng_rdata;
    logic [3:0]  lane_ok;
    logic        all_match;
    logic        simple_op;
    logic [2:0]  seq_last;
    logic [31:0] tmo_limit;
    logic [26:0] step_word;
    logic [3:0]  wr_cnt_reg;

    sfh_cycle u_cycle (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .start    (start_reg),
        .is_flash (eng_flash_reg),
        .is_write (eng_write_reg),
        .addr     (eng_addr_reg),
        .wdata    (eng_wdata_reg),
        .lanes    (eng_lanes_reg),
        .data_in  (data_in),
        .done     (eng_done),
        .rdata    (eng_rdata),
        .pins     (pins)
    );

    // ==========================================================
    // Flash command word for a step: address and lane byte
    function automatic logic [26:0] cmd_step(input sfh_op_e op, input logic [2:0] step);
        logic [26:0] w;
        w = {SFH_UNLOCK1_ADDR, SFH_UNLOCK1_DATA};
        case (step)
            3'h1, 3'h4: w = {SFH_UNLOCK2_ADDR, SFH_UNLOCK2_DATA};
            3'h2:       w = {SFH_UNLOCK1_ADDR, (op == SFH_OP_PROG) ? SFH_PROG_CODE : SFH_ERASE_CODE};
            3'h5:       w = {SFH_UNLOCK1_ADDR, SFH_CHIP_CODE};
            default:    w = {SFH_UNLOCK1_ADDR, SFH_UNLOCK1_DATA};
        endcase
        return w;
    endfunction

    always_comb begin
        simple_op = (cmd_reg.op == SFH_OP_SRAM_RD) || (cmd_reg.op == SFH_OP_SRAM_WR)
                    || (cmd_reg.op == SFH_OP_FLASH_RD);
        case (cmd_reg.op)
            SFH_OP_PROG:       seq_last = SFH_PROG_STEPS - 3'h1;
            SFH_OP_SECT_ERASE: seq_last = SFH_SECT_STEPS - 3'h1;
            SFH_OP_CHIP_ERASE: seq_last = SFH_CHIP_STEPS - 3'h1;
            default:           seq_last = 3'h0;
        endcase
        case (cmd_reg.op)
            SFH_OP_CHIP_ERASE: tmo_limit = CHIP_TMO_CYC;
            SFH_OP_SECT_ERASE: tmo_limit = SECT_TMO_CYC;
            default:           tmo_limit = PROG_TMO_CYC;
        endcase
        step_word = cmd_step(cmd_reg.op, step_reg);
    end

    // ==========================================================
    // Completion poll: each active lane compares its bit 7
    for (genvar i = 0; i < SFH_LANES; i++) begin : g_lane
        assign lane_ok[i] = !cmd_reg.lanes[i]
            || (eng_rdata[8*i+SFH_POLL_BIT] ==
                ((cmd_reg.op == SFH_OP_PROG) ? cmd_reg.data[8*i+SFH_POLL_BIT] : 1'b1));
    end
    assign all_match = &lane_ok;

    // ==========================================================
    // Command sequencing
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_reg     <= SFH_M_IDLE;
            cmd_reg       <= '0;
            step_reg      <= 3'h0;
            sect_reg      <= 3'h0;
            wait_reg      <= 1'b0;
            start_reg     <= 1'b0;
            eng_flash_reg <= 1'b0;
            eng_write_reg <= 1'b0;
            eng_addr_reg  <= 19'h0;
            eng_wdata_reg <= 32'h0;
            eng_lanes_reg <= 4'h0;
            poll_addr_reg <= 19'h0;
            tmo_reg       <= 32'h0;
            fail_reg      <= 1'b0;
        end else begin
            start_reg <= 1'b0;
            case (state_reg)
                SFH_M_IDLE: begin
                    if (cmd_valid && cmd_ready) begin
                        cmd_reg       <= cmd;
                        step_reg      <= 3'h0;
                        sect_reg      <= 3'h0;
                        wait_reg      <= 1'b0;
                        poll_addr_reg <= cmd.addr;
                        tmo_reg       <= 32'h0;
                        fail_reg      <= 1'b0;
                        state_reg     <= SFH_M_SEQ;
                    end
                end
                SFH_M_SEQ: begin
                    if (!wait_reg) begin
                        start_reg     <= 1'b1;
                        wait_reg      <= 1'b1;
                        eng_lanes_reg <= cmd_reg.lanes;
                        if (simple_op) begin
                            eng_flash_reg <= (cmd_reg.op == SFH_OP_FLASH_RD);
                            eng_write_reg <= (cmd_reg.op == SFH_OP_SRAM_WR);
                            eng_addr_reg  <= cmd_reg.addr;
                            eng_wdata_reg <= cmd_reg.data;
                        end else if (cmd_reg.op == SFH_OP_PROG && step_reg == seq_last) begin
                            eng_flash_reg <= 1'b1;
                            eng_write_reg <= 1'b1;
                            eng_addr_reg  <= cmd_reg.addr;
                            eng_wdata_reg <= cmd_reg.data;
                        end else begin
                            eng_flash_reg <= 1'b1;
                            eng_write_reg <= 1'b1;
                            eng_addr_reg  <= step_word[26:8];
                            eng_wdata_reg <= {SFH_LANES{step_word[7:0]}};
                        end
                    end else if (eng_done) begin
                        wait_reg <= 1'b0;
                        step_reg <= step_reg + 3'h1;
                        if (step_reg == seq_last) begin
                            if (simple_op) begin
                                state_reg <= SFH_M_DONE;
                            end else if (cmd_reg.op == SFH_OP_SECT_ERASE) begin
                                state_reg <= SFH_M_SECT;
                            end else begin
                                state_reg <= SFH_M_POLL;
                            end
                        end
                    end
                end
                SFH_M_SECT: begin
                    if (!wait_reg) begin
                        if (cmd_reg.data[sect_reg]) begin
                            start_reg     <= 1'b1;
                            wait_reg      <= 1'b1;
                            eng_addr_reg  <= {sect_reg, 16'h0000};
                            eng_wdata_reg <= {SFH_LANES{SFH_SECT_CODE}};
                            poll_addr_reg <= {sect_reg, 16'h0000};
                        end else if (sect_reg == 3'(SFH_SECTORS - 1)) begin
                            state_reg <= SFH_M_POLL;
                        end else begin
                            sect_reg <= sect_reg + 3'h1;
                        end
                    end else if (eng_done) begin
                        wait_reg <= 1'b0;
                        if (sect_reg == 3'(SFH_SECTORS - 1)) begin
                            state_reg <= SFH_M_POLL;
                        end else begin
                            sect_reg <= sect_reg + 3'h1;
                        end
                    end
                end
                SFH_M_POLL: begin
                    tmo_reg <= tmo_reg + 32'h1;
                    if (!wait_reg) begin
                        start_reg     <= 1'b1;
                        wait_reg      <= 1'b1;
                        eng_flash_reg <= 1'b1;
                        eng_write_reg <= 1'b0;
                        eng_addr_reg  <= poll_addr_reg;
                    end else if (eng_done) begin
                        wait_reg <= 1'b0;
                        if (all_match || tmo_reg >= tmo_limit) begin
                            fail_reg  <= !all_match;
                            state_reg <= SFH_M_DONE;
                        end
                    end
                end
                SFH_M_DONE: state_reg <= SFH_M_IDLE;
                default:    state_reg <= SFH_M_IDLE;
            endcase
        end
    end

    // ==========================================================
    // Handshake and answer
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cmd_ready    <= 1'b0;
            resp_valid   <= 1'b0;
            resp_data    <= 32'h0;
            resp_timeout <= 1'b0;
        end else begin
            cmd_ready    <= (state_reg == SFH_M_IDLE && !(cmd_valid && cmd_ready))
                            || state_reg == SFH_M_DONE;
            resp_valid   <= (state_reg == SFH_M_DONE);
            resp_timeout <= (state_reg == SFH_M_DONE) && fail_reg;
            if (state_reg == SFH_M_DONE) begin
                resp_data <= eng_rdata;
            end
        end
    end

    // ==========================================================
    // Checks
    always_ff @(posedge ref_clk) begin
        if (rst || state_reg == SFH_M_IDLE) begin
            wr_cnt_reg <= 4'h0;
        end else if (start_reg && eng_write_reg) begin
            wr_cnt_reg <= wr_cnt_reg + 4'h1;
        end
    end

    a_prog_four_writes: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(state_reg == SFH_M_POLL) && cmd_reg.op == SFH_OP_PROG |-> wr_cnt_reg == 4'h4)
        else $error("program sequence not four writes");
    a_prog_final_cycle: assert property (@(posedge ref_clk) disable iff (rst)
        start_reg && cmd_reg.op == SFH_OP_PROG && state_reg == SFH_M_SEQ && step_reg == 3'h3
        |-> eng_addr_reg == cmd_reg.addr && eng_wdata_reg == cmd_reg.data)
        else $error("final program cycle lacks location or value");
    a_erase_sector_addr: assert property (@(posedge ref_clk) disable iff (rst)
        start_reg && state_reg == SFH_M_SECT |->
            cmd_reg.data[eng_addr_reg[18:16]] && eng_addr_reg[15:0] == 16'h0000)
        else $error("sector erase address wrong");
    a_poll_gates_done: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(state_reg == SFH_M_DONE) && !simple_op |-> all_match || fail_reg)
        else $error("flash op finished without poll match");
    a_resp_after_done: assert property (@(posedge ref_clk) disable iff (rst)
        state_reg == SFH_M_DONE |=> resp_valid && cmd_ready ##1 !resp_valid)
        else $error("answer pulse wrong");

    c_sram_write: cover property (@(posedge ref_clk) disable iff (rst)
        resp_valid && cmd_reg.op == SFH_OP_SRAM_WR);
    c_prog_done: cover property (@(posedge ref_clk) disable iff (rst)
        resp_valid && cmd_reg.op == SFH_OP_PROG && !resp_timeout);
    c_sect_erase_done: cover property (@(posedge ref_clk) disable iff (rst)
        resp_valid && cmd_reg.op == SFH_OP_SECT_ERASE);
    c_poll_timeout: cover property (@(posedge ref_clk) disable iff (rst)
        resp_timeout);
endmodule
`default_nettype wire

/* File: sfh_mem_model.sv */
// Behavioural SRAM and flash module model on the host's pins
`timescale 1ns/100ps
`default_nettype none
module sfh_mem_model #(
    parameter int BUSY_CYC = 40 // Internal operation length, scaled down
) (
    input  wire logic               ref_clk, // Paces the model
    input  wire sfh_pkg::sfh_pins_s pins,    // Host pins
    output logic [31:0]             data_in  // Resolved shared bus
);
    import sfh_pkg::*;
    // ==========================================================
    // Arrays, command decode and bus resolution
    logic [31:0] sram[logic [18:0]];
    logic [31:0] fl[logic [18:0]];
    logic [31:0] last_reg;
    logic [2:0]  step_reg;
    int          busy_reg;
    sfh_pins_s   q;
    logic [3:0]  sw;
    logic [3:0]  fw;
    logic [7:0]  b;
    initial begin
        last_reg = 32'h0;
        step_reg = 3'h0;
        busy_reg = 0;
    end
    always @* begin
        if (!pins.data_oe_n)
            data_in = pins.data_out;
        else if (!pins.sram_select_n && !pins.output_enable_n && &pins.sram_write_strobe_n)
            data_in = sram[pins.addr];
        else if (!pins.flash_select_n && !pins.output_enable_n)
            data_in = (fl.exists(pins.addr) ? fl[pins.addr] : 32'hffffffff)
                      ^ (busy_reg != 0 ? 32'h80808080 : 32'h0);
        else
            data_in = ~last_reg;
    end
    // Write ends when strobe or select rises, whichever is first
    always @(posedge ref_clk) begin
        sw = ~{4{q.sram_select_n}} & ~q.sram_write_strobe_n
             & (pins.sram_write_strobe_n | {4{pins.sram_select_n}});
        fw = ~{4{q.flash_select_n}} & ~q.flash_write_strobe_n
             & (pins.flash_write_strobe_n | {4{pins.flash_select_n}});
        b = q.data_out[7:0];
        last_reg <= data_in;
        if (busy_reg != 0)
            busy_reg <= busy_reg - 1;
        for (int i = 0; i < 4; i++)
            if (sw[i])
                sram[q.addr][8*i+:8] = q.data_out[8*i+:8];
        if (|fw) begin
            if (step_reg == 3'h3) begin
                if (!fl.exists(q.addr))
                    fl[q.addr] = 32'hffffffff;
                for (int i = 0; i < 4; i++)
                    if (fw[i])
                        fl[q.addr][8*i+:8] = q.data_out[8*i+:8];
                busy_reg <= BUSY_CYC;
                step_reg <= 3'h0;
            end else if (step_reg == 3'h6 && b == 8'h30) begin
                foreach (fl[k])
                    if (k[18:16] == q.addr[18:16])
                        fl[k] = 32'hffffffff;
                busy_reg <= BUSY_CYC;
            end else if (step_reg == 3'h6 && b == 8'h10) begin
                fl.delete();
                busy_reg <= BUSY_CYC;
                step_reg <= 3'h0;
            end else if (step_reg == 3'h2)
                step_reg <= b == 8'ha0 ? 3'h3 : b == 8'h80 ? 3'h4 : 3'h0;
            else if ((step_reg == 3'h1 || step_reg == 3'h5) && b == 8'h55)
                step_reg <= step_reg + 3'h1;
            else
                step_reg <= b == 8'haa ? (step_reg == 3'h4 ? 3'h5 : 3'h1) : 3'h0;
        end
        q <= pins;
    end
endmodule
`default_nettype wire

/* File: tb_top.sv */
// Self-checking testbench for the host SRAM and flash controller
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import sfh_pkg::*;
    // ==========================================================
    // Design, model and scenarios
    logic        ref_clk = 1'b0;
    logic        rst = 1'b1;
    logic        cmd_valid = 1'b0;
    sfh_cmd_s    cmd = '0;
    logic        cmd_ready;
    logic        resp_valid;
    logic        resp_timeout;
    logic [31:0] resp_data;
    logic [31:0] data_in;
    sfh_pins_s   pins;
    int          error_cnt = 0;
    int          n_compared = 0;
    always #25 ref_clk = ~ref_clk;
    sfh_ctrl #(.PROG_TMO_CYC(32'h100), .SECT_TMO_CYC(32'h100), .CHIP_TMO_CYC(32'h100)) dut_u (
        .ref_clk(ref_clk), .rst(rst), .cmd_valid(cmd_valid), .cmd(cmd),
        .cmd_ready(cmd_ready), .resp_valid(resp_valid), .resp_data(resp_data),
        .resp_timeout(resp_timeout), .data_in(data_in), .pins(pins));
    sfh_mem_model #(.BUSY_CYC(40)) mem_u (.ref_clk(ref_clk), .pins(pins), .data_in(data_in));
    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic run(sfh_op_e op, logic [18:0] a, logic [31:0] d, logic [3:0] ln);
        int n;
        @(negedge ref_clk);
        cmd = '{op, a, d, ln};
        cmd_valid = 1'b1;
        for (n = 0; n < 50 && cmd_ready !== 1'b1; n++)
            @(negedge ref_clk);
        @(negedge ref_clk);
        cmd_valid = 1'b0;
        for (n = 0; n < 3000 && resp_valid !== 1'b1; n++)
            @(negedge ref_clk);
        chk("response", 32'h1, {31'h0, resp_valid});
        chk("timeout", 32'h0, {31'h0, resp_timeout});
    endtask
    task automatic t_sram();
        run(SFH_OP_SRAM_WR, 19'h7ffff, 32'habcdef01, 4'hf);
        run(SFH_OP_SRAM_WR, 19'h7ffff, 32'h11223344, 4'h5);
        run(SFH_OP_SRAM_RD, 19'h7ffff, 32'h0, 4'hf);
        chk("sram word", 32'hab22ef44, resp_data);
        run(SFH_OP_FLASH_RD, 19'h7ffff, 32'h0, 4'hf);
        chk("flash blank", 32'hffffffff, resp_data);
        $display("done sram");
    endtask
    task automatic t_prog();
        run(SFH_OP_PROG, 19'h01234, 32'h5a0f00a5, 4'hf);
        chk("prog poll", 32'h5a0f00a5, resp_data);
        run(SFH_OP_FLASH_RD, 19'h01234, 32'h0, 4'hf);
        chk("prog word", 32'h5a0f00a5, resp_data);
        $display("done program");
    endtask
    task automatic t_erase();
        logic [18:0] a[3] = '{19'h20000, 19'h50000, 19'h30000};
        logic [31:0] e[3] = '{32'hffffffff, 32'hffffffff, 32'h0};
        foreach (a[i])
            run(SFH_OP_PROG, a[i], 32'h0, 4'hf);
        run(SFH_OP_SECT_ERASE, 19'h0, 32'h24, 4'hf);
        foreach (a[i]) begin
            run(SFH_OP_FLASH_RD, a[i], 32'h0, 4'hf);
            chk("sector word", e[i], resp_data);
        end
        run(SFH_OP_CHIP_ERASE, 19'h30000, 32'h0, 4'hf);
        run(SFH_OP_FLASH_RD, 19'h30000, 32'h0, 4'hf);
        chk("chip word", 32'hffffffff, resp_data);
        $display("done erase");
    endtask
    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (3) @(negedge ref_clk);
        rst = 1'b0;
        chk("idle select", 32'h1, {31'h0, pins.sram_select_n});
        t_sram();
        t_prog();
        t_erase();
        tally_and_finish();
    end
    initial begin
        #2000000;
        error_cnt++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
